// [common/adc_cal_defs.svh]
`ifndef ADC_CAL_DEFS_SVH
`define ADC_CAL_DEFS_SVH

// Register offsets
`define OFS_OSC_TUNE          8'h59
`define OFS_SYNTH_HOLD        8'h5c
`define OFS_OSC_CAL_CONTROL   8'h5d
`define OFS_OSC_CAL_STATUS    8'h5e
`define OFS_ADC_CAL_ENABLE    8'h61
`define OFS_ADC_CALIB_CFG_A   8'h62

// Field positions
`define OSC_SETTLE_MSB        6
`define OSC_SETTLE_LSB        4
`define OSC_ENABLE_BIT        0
`define CFG_BG_OFFSET_BIT     3
`define CFG_FG_OFFSET_BIT     2
`define CFG_BG_CAL_BIT        1
`define CFG_FG_RUN_BIT        0

// Reset values
`define RST_OSC_TUNE          7'h00
`define RST_SYNTH_HOLD        1'b0
`define RST_OSC_SETTLE        3'h4
`define RST_OSC_ENABLE        1'b0
`define RST_CAL_RUN           1'b1
`define RST_CALIB_CFG         4'h1

// Timing: base settle wait in cycles, doubled per settle code step
`define OSC_SETTLE_BASE       12'h010
`define OSC_TUNE_MSB_IDX      3'h6

`endif

// [common/adc_cal_pkg.sv]
package adc_cal_pkg;

    typedef enum logic {
        OSC_IDLE,
        OSC_SETTLE
    } osc_state_t;

    typedef enum logic [2:0] {
        CAL_HOLD,
        CAL_CLEAR,
        FG_STEP,
        BG_STEP,
        CAL_DONE
    } cal_state_t;

    typedef struct packed {
        logic [6:0]  tune;
        logic        hold;
        logic        hold_d;
        logic [2:0]  settle;
        logic        osc_en;
        logic        osc_done;
        osc_state_t  osc_st;
        logic [2:0]  bit_idx;
        logic [11:0] wait_cnt;
        logic        cal_run;
        logic [3:0]  cfg;
        cal_state_t  cal_st;
        logic [7:0]  rdata;
    } state_t;

endpackage

// [rtl/adc_calibration_control.sv]
`timescale 1ns/100ps
`include "adc_cal_defs.svh"
// Contract
// R1: Settle field scales wait after each tune step
// R2: Oscillator calibration starts when synth hold released
// R3: Engine searches tune code toward reference centre
// R4: Host changes oscillator control only under hold
// R5: Complete flag set after finish or skip
// R6: Host leaves tune code alone while running
// R7: Run bit resets one; zero holds calibration
// R8: Clearing run bit resets processing/link dividers
// R9: Clear run, reconfigure, set run again
// R10: Run before link enable; link off first
// R11: Bit 3 background offset, needs background
// R12: Bit 2 foreground offset, needs foreground
// R13: Bit 1 enables background calibration
// R14: Bit 0 clears values, selects foreground run; code clears on every run start, bit 0 only selects foreground
// R15: Host sets hold around synthesizer programming
// R16: Seven-bit tune code, engine fills, host reloads
// R17: Run rising edge starts sequence, foreground first
module adc_calibration_control
    import adc_cal_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic       reg_wr_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic      [7:0] reg_rdata_o,
    input  wire logic       osc_fast_i,
    input  wire logic       fg_cal_done_i,
    output logic      [6:0] osc_tune_code_o,
    output logic            synth_hold_o,
    output logic            osc_cal_complete_o,
    output logic            cal_reset_o,
    output logic            divider_reset_o,
    output logic            clear_cal_o,
    output logic            fg_cal_active_o,
    output logic            fg_offset_cal_o,
    output logic            bg_cal_active_o,
    output logic            bg_offset_cal_o
);

    state_t s;
    state_t next_s;
    logic   wr_tune;
    logic   hold_fell;

    // Write decode for the engine-shared tune register
    assign wr_tune   = reg_wr_i && (reg_addr_i == `OFS_OSC_TUNE);
    assign hold_fell = s.hold_d && !s.hold;

    // Next-state logic for registers, oscillator engine and calibration sequencer
    always_comb begin
        next_s        = s;
        next_s.hold_d = s.hold;

        // Register writes; reserved bits are not stored and read zero
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                `OFS_SYNTH_HOLD:      next_s.hold = reg_wdata_i[0];
                `OFS_OSC_CAL_CONTROL: begin
                    next_s.settle = reg_wdata_i[`OSC_SETTLE_MSB:`OSC_SETTLE_LSB];
                    next_s.osc_en = reg_wdata_i[`OSC_ENABLE_BIT];
                end
                `OFS_ADC_CAL_ENABLE:  next_s.cal_run = reg_wdata_i[0];
                `OFS_ADC_CALIB_CFG_A: next_s.cfg = reg_wdata_i[3:0];
                default: ;
            endcase
        end
        // Engine owns the tune code while running; host writes then dropped
        if (wr_tune && s.osc_st == OSC_IDLE) begin
            next_s.tune = reg_wdata_i[6:0]; // [R16]
        end

        // Oscillator calibration engine, successive approximation MSB first
        if (s.hold) begin
            // Hold aborts any search and invalidates the result
            next_s.osc_st   = OSC_IDLE;
            next_s.osc_done = 1'b0;
        end else begin
            unique case (s.osc_st)
                OSC_IDLE: begin
                    if (hold_fell && s.osc_en) begin
                        next_s.osc_st   = OSC_SETTLE; // [R2]
                        next_s.osc_done = 1'b0;
                        next_s.bit_idx  = `OSC_TUNE_MSB_IDX;
                        next_s.tune     = 7'h40;
                        next_s.wait_cnt = (`OSC_SETTLE_BASE << s.settle) - 12'h001; // [R1]
                    end else if (!s.osc_en) begin
                        next_s.osc_done = 1'b1; // [R5]
                    end
                end
                OSC_SETTLE: begin
                    if (s.wait_cnt != 12'h000) begin
                        next_s.wait_cnt = s.wait_cnt - 12'h001; // [R1]
                    end else begin
                        // Oscillator above target: back this bit out
                        if (osc_fast_i) begin
                            next_s.tune[s.bit_idx] = 1'b0; // [R3]
                        end
                        if (s.bit_idx == 3'h0) begin
                            next_s.osc_st   = OSC_IDLE;
                            next_s.osc_done = 1'b1; // [R5]
                        end else begin
                            next_s.bit_idx                 = s.bit_idx - 3'h1;
                            next_s.tune[s.bit_idx - 3'h1] = 1'b1; // [R3]
                            next_s.wait_cnt = (`OSC_SETTLE_BASE << s.settle) - 12'h001;
                        end
                    end
                end
            endcase
        end

        // Converter calibration sequencer; a cleared run bit holds everything
        if (!s.cal_run) begin
            next_s.cal_st = CAL_HOLD; // [R7]
        end else begin
            unique case (s.cal_st)
                CAL_HOLD:  next_s.cal_st = CAL_CLEAR; // [R17]
                CAL_CLEAR: begin
                    // Stored values always cleared; foreground only when selected
                    if (s.cfg[`CFG_FG_RUN_BIT]) begin
                        next_s.cal_st = FG_STEP; // [R14]
                    end else if (s.cfg[`CFG_BG_CAL_BIT]) begin
                        next_s.cal_st = BG_STEP; // [R13]
                    end else begin
                        next_s.cal_st = CAL_DONE;
                    end
                end
                FG_STEP: begin
                    if (fg_cal_done_i) begin
                        next_s.cal_st = s.cfg[`CFG_BG_CAL_BIT] ? BG_STEP : CAL_DONE; // [R17]
                    end
                end
                BG_STEP: begin
                    if (!s.cfg[`CFG_BG_CAL_BIT]) begin
                        next_s.cal_st = CAL_DONE; // [R13]
                    end
                end
                CAL_DONE: ;
                default:  next_s.cal_st = CAL_HOLD;
            endcase
        end

        // Read data, one cycle after the address is presented
        unique case (reg_addr_i)
            `OFS_OSC_TUNE:        next_s.rdata = {1'b0, s.tune};
            `OFS_SYNTH_HOLD:      next_s.rdata = {7'h00, s.hold};
            `OFS_OSC_CAL_CONTROL: next_s.rdata = {1'b0, s.settle, 3'h0, s.osc_en};
            `OFS_OSC_CAL_STATUS:  next_s.rdata = {7'h00, s.osc_done};
            `OFS_ADC_CAL_ENABLE:  next_s.rdata = {7'h00, s.cal_run};
            `OFS_ADC_CALIB_CFG_A: next_s.rdata = {4'h0, s.cfg};
            default:              next_s.rdata = 8'h00;
        endcase
    end

    // State register; run bit resets high so calibration follows power-up
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s          <= '0;
            s.tune     <= `RST_OSC_TUNE;
            s.hold     <= `RST_SYNTH_HOLD;
            s.settle   <= `RST_OSC_SETTLE;
            s.osc_en   <= `RST_OSC_ENABLE;
            s.osc_st   <= OSC_IDLE;
            s.cal_run  <= `RST_CAL_RUN;
            s.cfg      <= `RST_CALIB_CFG;
            s.cal_st   <= CAL_HOLD;
        end else begin
            s <= next_s;
        end
    end

    // Outputs
    assign reg_rdata_o        = s.rdata;
    assign osc_tune_code_o    = s.tune;
    assign synth_hold_o       = s.hold;
    assign osc_cal_complete_o = s.osc_done;
    assign cal_reset_o        = !s.cal_run;                                  // [R7]
    assign divider_reset_o    = !s.cal_run;                                  // [R8]
    assign clear_cal_o        = (s.cal_st == CAL_CLEAR);                     // [R14]
    assign fg_cal_active_o    = (s.cal_st == FG_STEP);
    assign fg_offset_cal_o    = fg_cal_active_o && s.cfg[`CFG_FG_OFFSET_BIT]; // [R12]
    assign bg_cal_active_o    = (s.cal_st == BG_STEP);                       // [R13]
    assign bg_offset_cal_o    = bg_cal_active_o && s.cfg[`CFG_BG_OFFSET_BIT]; // [R11]

    // Checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence seq_hold_release;
        $fell(s.hold) && s.osc_en;
    endsequence

    sequence seq_clear_step;
        s.cal_run && s.cal_st == CAL_CLEAR;
    endsequence

    AST_SETTLE_STABLE: assert property ( // [R1]
        (s.osc_st == OSC_SETTLE && s.wait_cnt != 12'h000 && !s.hold) |=> $stable(s.tune)
    ) else $error("tune code moved during settle wait");

    AST_OSC_START: assert property ( // [R2]
        seq_hold_release |=> s.osc_st == OSC_SETTLE && s.tune == 7'h40 && !s.osc_done
    ) else $error("oscillator search did not start on hold release");

    AST_OSC_FINISH: assert property ( // [R3]
        (s.osc_st == OSC_SETTLE && s.wait_cnt == 12'h000 && s.bit_idx == 3'h0 && !s.hold)
        |=> osc_cal_complete_o && s.osc_st == OSC_IDLE
    ) else $error("oscillator search did not finish after last bit");

    AST_OSC_SKIP: assert property ( // [R5]
        (!s.hold && !s.osc_en && s.osc_st == OSC_IDLE) |=> osc_cal_complete_o
    ) else $error("complete flag not set when calibration skipped");

    AST_RUN_LOW_HOLDS: assert property ( // [R7]
        (reg_wr_i && reg_addr_i == `OFS_ADC_CAL_ENABLE && !reg_wdata_i[0])
        |=> (cal_reset_o && divider_reset_o) ##1 (s.cal_st == CAL_HOLD) // [R8]
    ) else $error("run bit clear did not hold calibration and dividers");

    AST_BG_OFFSET_GATED: assert property ( // [R11]
        bg_offset_cal_o |-> bg_cal_active_o && s.cfg[`CFG_BG_CAL_BIT]
    ) else $error("background offset active without background calibration");

    AST_FG_OFFSET_GATED: assert property ( // [R12]
        fg_offset_cal_o |-> fg_cal_active_o && s.cfg[`CFG_FG_RUN_BIT]
    ) else $error("foreground offset active without foreground calibration");

    AST_FG_SELECT: assert property ( // [R14]
        seq_clear_step |=> (s.cal_st == FG_STEP) == $past(s.cfg[`CFG_FG_RUN_BIT])
    ) else $error("foreground step does not follow bit 0");

    AST_RUN_RISE_CLEARS: assert property ( // [R17]
        $rose(s.cal_run) |=> clear_cal_o ##1 !clear_cal_o
    ) else $error("run bit rise did not clear calibration values once");

    AST_TUNE_RELOAD: assert property ( // [R16]
        (wr_tune && s.osc_st == OSC_IDLE) |=> osc_tune_code_o == $past(reg_wdata_i[6:0])
    ) else $error("host tune reload lost");

endmodule // adc_calibration_control

// [verification/testbench.sv]
`timescale 1ns/100ps
`include "adc_cal_defs.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fail_count++; \
    $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module testbench;
    logic       core_clk_i = 1'b0;
    logic       sys_rst_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic       reg_wr_i = 1'b0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic [7:0] reg_rdata_o;
    logic       osc_fast_i = 1'b0;
    logic       fg_cal_done_i = 1'b0;
    logic [6:0] osc_tune_code_o;
    logic       synth_hold_o, osc_cal_complete_o, cal_reset_o, divider_reset_o;
    logic       clear_cal_o, fg_cal_active_o, fg_offset_cal_o;
    logic       bg_cal_active_o, bg_offset_cal_o;
    logic [6:0] target = 7'h2b;
    int         fail_count = 0;
    int         cmp_count = 0;
    int         n1, n2, nc;

    adc_calibration_control adc_calibration_control_i (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .osc_fast_i(osc_fast_i), .fg_cal_done_i(fg_cal_done_i),
        .osc_tune_code_o(osc_tune_code_o), .synth_hold_o(synth_hold_o),
        .osc_cal_complete_o(osc_cal_complete_o), .cal_reset_o(cal_reset_o),
        .divider_reset_o(divider_reset_o), .clear_cal_o(clear_cal_o),
        .fg_cal_active_o(fg_cal_active_o), .fg_offset_cal_o(fg_offset_cal_o),
        .bg_cal_active_o(bg_cal_active_o), .bg_offset_cal_o(bg_offset_cal_o));

    // Clock, 100 ns period
    always #50 core_clk_i = ~core_clk_i;

    // Oscillator comparator: above target means too fast
    always @(posedge core_clk_i) begin
        osc_fast_i <= (osc_tune_code_o > target);
    end

    // One write per call; strobe dropped at the taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i    <= 1'b0;
    endtask

    // Read back and compare; extra edge keeps clear of the flop update
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        repeat (2) @(posedge core_clk_i);
        #1;
        `CHK(reg_rdata_o, e)
    endtask

    // Bounded wait for a level or pulse, sampled once per cycle
    task automatic wt(ref logic s, output int n);
        for (n = 0; n < 2000; n++) begin
            @(posedge core_clk_i);
            #1;
            if (s === 1'b1) break;
        end
    endtask

    task automatic fg_done();
        @(posedge core_clk_i);
        fg_cal_done_i <= 1'b1;
        @(posedge core_clk_i);
        fg_cal_done_i <= 1'b0;
    endtask

    // Full search: hold, program, release, tune write that must be dropped
    task automatic osc_run(input logic [2:0] stl, output int n);
        wr(`OFS_SYNTH_HOLD, 8'h01);
        rc(`OFS_OSC_CAL_STATUS, 8'h00);
        wr(`OFS_OSC_CAL_CONTROL, {1'b0, stl, 4'h1});
        wr(`OFS_SYNTH_HOLD, 8'h00);
        wr(`OFS_OSC_TUNE, 8'h7f);
        wt(osc_cal_complete_o, n);
        `CHK(osc_cal_complete_o, 1'b1)
        `CHK(osc_tune_code_o, target)
    endtask

    task automatic test_done();
        if (fail_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Watchdog well beyond the expected few hundred cycles
    initial begin
        repeat (20000) @(posedge core_clk_i);
        fail_count++;
        test_done();
    end

    // Main sequence
    initial begin
        repeat (16) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        wt(fg_cal_active_o, nc);
        `CHK(fg_cal_active_o, 1'b1)
        `CHK(fg_offset_cal_o, 1'b0)
        rc(`OFS_OSC_TUNE, 8'h00);
        rc(`OFS_SYNTH_HOLD, 8'h00);
        rc(`OFS_OSC_CAL_CONTROL, 8'h40);
        rc(`OFS_OSC_CAL_STATUS, 8'h01);
        rc(`OFS_ADC_CAL_ENABLE, 8'h01);
        rc(`OFS_ADC_CALIB_CFG_A, 8'h01);
        rc(8'h60, 8'h00);
        fg_done();
        rc(`OFS_ADC_CAL_ENABLE, 8'h01);
        `CHK({fg_cal_active_o, bg_cal_active_o}, 2'b00)
        // Oscillator search, short then longer settle
        osc_run(3'h0, n1);
        target = 7'h55;
        osc_run(3'h1, n2);
        `CHK(n2 > n1, 1'b1)
        wr(`OFS_OSC_TUNE, 8'h91);
        rc(`OFS_OSC_TUNE, 8'h11);
        // Skipped search: enable clear, reserved bits dropped
        wr(`OFS_SYNTH_HOLD, 8'h01);
        wr(`OFS_OSC_CAL_CONTROL, 8'hce);
        rc(`OFS_OSC_CAL_CONTROL, 8'h40);
        wr(`OFS_SYNTH_HOLD, 8'h00);
        rc(`OFS_OSC_CAL_STATUS, 8'h01);
        // Run bit low holds calibration and dividers
        wr(`OFS_ADC_CAL_ENABLE, 8'h00);
        rc(`OFS_ADC_CAL_ENABLE, 8'h00);
        `CHK({cal_reset_o, divider_reset_o}, 2'b11)
        wr(`OFS_ADC_CALIB_CFG_A, 8'hff);
        rc(`OFS_ADC_CALIB_CFG_A, 8'h0f);
        wr(`OFS_ADC_CAL_ENABLE, 8'h01);
        wt(clear_cal_o, nc);
        `CHK(clear_cal_o, 1'b1)
        wt(fg_cal_active_o, nc);
        `CHK({cal_reset_o, divider_reset_o}, 2'b00)
        `CHK({fg_offset_cal_o, bg_cal_active_o}, 2'b10)
        fg_done();
        wt(bg_cal_active_o, nc);
        `CHK({fg_cal_active_o, bg_offset_cal_o}, 2'b01)
        wr(`OFS_ADC_CAL_ENABLE, 8'h00);
        rc(`OFS_ADC_CAL_ENABLE, 8'h00);
        `CHK({bg_cal_active_o, bg_offset_cal_o}, 2'b00)
        // Offset alone without foreground must stay off
        wr(`OFS_ADC_CALIB_CFG_A, 8'h04);
        wr(`OFS_ADC_CAL_ENABLE, 8'h01);
        wt(clear_cal_o, nc);
        `CHK(clear_cal_o, 1'b1)
        repeat (3) @(posedge core_clk_i);
        #1;
        `CHK({fg_cal_active_o, fg_offset_cal_o}, 2'b00)
        test_done();
    end
endmodule // testbench
